// [rtl/rs16_pkg.sv]
/*
 * Shared constants and carrier types for the regenerator-section termination block.
 * Assumes a byte-wide line interface, one byte per rising link clock edge, 9 x 4320 bytes a frame.
 */
package rs16_pkg;

    // ****************************************************************
    // Frame geometry
    // ****************************************************************
    localparam int unsigned FRAME_ROWS    = 9;
    localparam int unsigned FRAME_COLS    = 4320;
    localparam int unsigned SOH_COLS      = 144;
    localparam int unsigned RSOH_ROWS     = 3;
    localparam int unsigned A1_LAST_COL   = 48;
    localparam int unsigned A2_LAST_COL   = 96;
    localparam int unsigned TRACE_COL     = 97;
    localparam int unsigned PARITY_ROW    = 2;
    localparam int unsigned PARITY_COL    = 1;
    localparam int unsigned SCR_RESET_COL = 145;
    localparam int unsigned PAYLOAD_BYTES = 38448;

    // ****************************************************************
    // Byte values
    // ****************************************************************
    localparam logic [7:0] A1_BYTE    = 8'hf6;
    localparam logic [7:0] A2_BYTE    = 8'h28;
    localparam logic [7:0] FILL_BYTE  = 8'haa;
    localparam logic [7:0] ONES_BYTE  = 8'hff;
    localparam logic [6:0] SCR_SEED   = 7'h7f;
    localparam logic [7:0] TRACE_RST  = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned MCLK_PERIOD_NS  = 100;
    localparam int unsigned AIS_TIME_US     = 250;
    localparam int unsigned AIS_MAX_CYCLES  = (AIS_TIME_US * 1000) / MCLK_PERIOD_NS;
    localparam int unsigned TRACE_PERSIST   = 3;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic       fs;
        logic [7:0] data;
    } line_byte_type;

    typedef struct packed {
        logic [11:0] col;
        logic [3:0]  row;
    } frame_pos_type;

endpackage

// [rtl/rs16_scrambler.sv]
/*
 * Frame-synchronous byte scrambler, 1 + x^6 + x^7, MSB of each byte first.
 * Assumes the caller marks the reset byte and every byte that is to be scrambled.
 */
`timescale 1ns/10ps
`default_nettype none

module rs16_scrambler
    import rs16_pkg::*;
(
    input  wire logic       clk,      // Link byte clock
    input  wire logic       rst_n,    // Synchronised reset, active low
    input  wire logic       load,     // Byte carries the reset bit
    input  wire logic       advance,  // Byte is scrambled
    input  wire logic [7:0] data_in,  // Byte before scrambling
    output logic      [7:0] data_out  // Byte after scrambling
);

    logic [6:0]  state;
    logic [14:0] step;

    // Returns {keystream byte, next state}; the keystream bit is the x7 stage
    function automatic logic [14:0] scr_step(input logic [6:0] s_in);
        logic [6:0] s;
        logic [7:0] ks;
        s  = s_in;
        ks = 8'h00;
        for (int i = 0; i < 8; i++) begin
            ks[7 - i] = s[6];
            s         = {s[5:0], s[6] ^ s[5]};
        end
        return {ks, s};
    endfunction

    assign step     = scr_step(load ? SCR_SEED : state);
    assign data_out = advance ? (data_in ^ step[14:7]) : data_in;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SCR_SEED;
        end else if (advance) begin
            state <= step[6:0];
        end
    end

endmodule

`default_nettype wire

// [rtl/stm16_regen_section_termination.sv]
/*
 * Regenerator-section termination with multiplex-section adaptation, both directions.
 * Assumes line bytes and frame starts arrive on link_clk, and management runs on mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module stm16_regen_section_termination
    import rs16_pkg::*;
#(
    parameter bit SRC_FAIL_CONNECTED = 1'b1  // Zero when nothing drives src_server_fail
)(
    input  wire logic          mclk,                     // Management clock, 10 MHz
    input  wire logic          arst_n,                   // Asynchronous reset, active low
    input  wire logic          link_clk,                 // Line byte clock
    input  wire line_byte_type src_in,                   // Payload byte and frame start
    input  wire logic          src_server_fail,          // Payload server fail, link domain
    output line_byte_type      tx_out,                   // Scrambled line byte
    input  wire line_byte_type rx_in,                    // Received scrambled line byte
    input  wire logic          server_fail_in,           // Line server fail, link domain
    output line_byte_type      rx_payload,               // Descrambled byte to multiplex side
    output logic               rx_payload_valid,         // Byte is a payload position
    output logic               ms_server_fail,           // Server fail to multiplex side
    input  wire logic [7:0]    transmit_trace_id,        // Provisioned trace to send
    input  wire logic [7:0]    expected_trace_id,        // Trace expected from far end
    input  wire logic          mismatch_detect_disable,  // Suppresses mismatch detection
    input  wire logic          monitoring_enabled,       // Gates the mismatch report
    output logic [7:0]         accepted_trace_id,        // Accepted received trace
    output logic               trace_mismatch_defect,    // Mismatch defect
    output logic               trace_mismatch_report,    // Gated mismatch report
    output logic               all_ones_insert_action,   // Sink all-ones insertion
    output logic               trail_fail_action,        // Trail signal fail
    output logic               block_error_indication    // One-cycle pulse per parity error
);

    // ****************************************************************
    // Reset synchronisers
    // ****************************************************************
    logic [1:0] mrst_pipe;
    logic [1:0] lrst_pipe;
    logic       mrst_n;
    logic       lrst_n;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mrst_pipe <= 2'b00;
        end else begin
            mrst_pipe <= {mrst_pipe[0], 1'b1};
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lrst_pipe <= 2'b00;
        end else begin
            lrst_pipe <= {lrst_pipe[0], 1'b1};
        end
    end

    assign mrst_n = mrst_pipe[1];
    assign lrst_n = lrst_pipe[1];

    // ****************************************************************
    // Frame position helpers
    // ****************************************************************
    function automatic frame_pos_type next_pos(input logic fs, input frame_pos_type p);
        frame_pos_type n;
        n = p;
        if (fs) begin
            n.row = 4'h1;
            n.col = 12'h001;
        end else if (p.col == 12'(FRAME_COLS)) begin
            n.col = 12'h001;
            n.row = (p.row == 4'(FRAME_ROWS)) ? 4'h1 : 4'(p.row + 4'h1);
        end else begin
            n.col = 12'(p.col + 12'h001);
        end
        return n;
    endfunction

    // Regenerator overhead occupies rows 1 to 3, columns 1 to 144
    function automatic logic in_rsoh(input frame_pos_type p);
        return (p.row <= 4'(RSOH_ROWS)) && (p.col <= 12'(SOH_COLS));
    endfunction

    // Row 1 overhead stays unscrambled
    function automatic logic scrambled_pos(input frame_pos_type p);
        return !((p.row == 4'h1) && (p.col <= 12'(SOH_COLS)));
    endfunction

    function automatic logic scr_reset_pos(input frame_pos_type p);
        return (p.row == 4'h1) && (p.col == 12'(SCR_RESET_COL));
    endfunction

    function automatic logic parity_pos(input frame_pos_type p);
        return (p.row == 4'(PARITY_ROW)) && (p.col == 12'(PARITY_COL));
    endfunction

    function automatic logic trace_pos(input frame_pos_type p);
        return (p.row == 4'h1) && (p.col == 12'(TRACE_COL));
    endfunction

    // ****************************************************************
    // Transmit trace crossing, mclk to link (request/acknowledge)
    // ****************************************************************
    logic [7:0] tx_trace_hold;
    logic       tx_trace_req;
    logic [1:0] tx_trace_ack_sync;
    logic [1:0] tx_trace_req_sync;
    logic       tx_trace_seen;
    logic [7:0] tx_trace_link;

    always_ff @(posedge mclk or negedge mrst_n) begin
        if (!mrst_n) begin
            tx_trace_hold     <= TRACE_RST;
            tx_trace_req      <= 1'b0;
            tx_trace_ack_sync <= 2'b00;
        end else begin
            tx_trace_ack_sync <= {tx_trace_ack_sync[0], tx_trace_seen};
            // Hold stays stable until the link side has taken it
            if (transmit_trace_id != tx_trace_hold && tx_trace_req == tx_trace_ack_sync[1]) begin
                tx_trace_hold <= transmit_trace_id;
                tx_trace_req  <= ~tx_trace_req;
            end
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_trace_req_sync <= 2'b00;
            tx_trace_seen     <= 1'b0;
            tx_trace_link     <= TRACE_RST;
        end else begin
            tx_trace_req_sync <= {tx_trace_req_sync[0], tx_trace_req};
            if (tx_trace_req_sync[1] != tx_trace_seen) begin
                tx_trace_link <= tx_trace_hold;
                tx_trace_seen <= tx_trace_req_sync[1];
            end
        end
    end

    // ****************************************************************
    // Source: overhead insertion, scrambling, parity
    // ****************************************************************
    frame_pos_type src_pos;
    frame_pos_type src_cur;
    logic          src_fail;
    logic [7:0]    src_byte;
    logic [7:0]    src_scr;
    logic [7:0]    src_bip_acc;
    logic [7:0]    src_bip_last;

    assign src_cur  = next_pos(src_in.fs, src_pos);
    assign src_fail = SRC_FAIL_CONNECTED ? src_server_fail : 1'b0;

    always_comb begin
        if (!in_rsoh(src_cur)) begin
            src_byte = src_fail ? ONES_BYTE : src_in.data;
        end else if (src_cur.row == 4'h1 && src_cur.col <= 12'(A1_LAST_COL)) begin
            src_byte = A1_BYTE;
        end else if (src_cur.row == 4'h1 && src_cur.col <= 12'(A2_LAST_COL)) begin
            src_byte = A2_BYTE;
        end else if (trace_pos(src_cur)) begin
            src_byte = tx_trace_link;
        end else if (parity_pos(src_cur)) begin
            src_byte = src_bip_last;
        end else begin
            // Channel bytes not carried here; alternating bits keep transitions
            src_byte = FILL_BYTE;
        end
    end

    rs16_scrambler u_src_scr (
        .clk      (link_clk),
        .rst_n    (lrst_n),
        .load     (scr_reset_pos(src_cur)),
        .advance  (scrambled_pos(src_cur)),
        .data_in  (src_byte),
        .data_out (src_scr)
    );

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            src_pos      <= '0;
            tx_out       <= '0;
            src_bip_acc  <= 8'h00;
            src_bip_last <= 8'h00;
        end else begin
            src_pos   <= src_cur;
            tx_out.fs <= src_in.fs;
            tx_out.data <= src_scr;
            if (src_in.fs) begin
                src_bip_last <= src_bip_acc;
                src_bip_acc  <= src_scr;
            end else begin
                src_bip_acc  <= src_bip_acc ^ src_scr;
            end
        end
    end

    // ****************************************************************
    // Sink: descrambling, parity check, trace capture
    // ****************************************************************
    frame_pos_type rx_pos;
    frame_pos_type rx_cur;
    logic [7:0]    rx_descr;
    logic [7:0]    rx_bip_acc;
    logic [7:0]    rx_bip_last;
    logic          rx_seen_fs;
    logic          rx_bip_valid;
    logic          rx_err_tgl;
    logic [7:0]    rx_trace_cand;
    logic [1:0]    rx_trace_cnt;
    logic [7:0]    rx_trace_acc;
    logic          rx_trace_tgl;
    logic [1:0]    ais_link_sync;
    logic [1:0]    tsf_link_sync;

    assign rx_cur = next_pos(rx_in.fs, rx_pos);

    rs16_scrambler u_rx_scr (
        .clk      (link_clk),
        .rst_n    (lrst_n),
        .load     (scr_reset_pos(rx_cur)),
        .advance  (scrambled_pos(rx_cur)),
        .data_in  (rx_in.data),
        .data_out (rx_descr)
    );

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_pos       <= '0;
            rx_bip_acc   <= 8'h00;
            rx_bip_last  <= 8'h00;
            rx_seen_fs   <= 1'b0;
            rx_bip_valid <= 1'b0;
            rx_err_tgl   <= 1'b0;
        end else begin
            rx_pos <= rx_cur;
            if (rx_in.fs) begin
                rx_bip_last  <= rx_bip_acc;
                rx_bip_acc   <= rx_in.data;
                rx_seen_fs   <= 1'b1;
                rx_bip_valid <= rx_seen_fs;
            end else begin
                rx_bip_acc   <= rx_bip_acc ^ rx_in.data;
            end
            // No check until one whole frame has been summed
            if (parity_pos(rx_cur) && rx_bip_valid && rx_descr != rx_bip_last) begin
                rx_err_tgl <= ~rx_err_tgl;
            end
        end
    end

    // Trace is accepted after the same byte in consecutive frames
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_trace_cand <= TRACE_RST;
            rx_trace_cnt  <= 2'd0;
            rx_trace_acc  <= TRACE_RST;
            rx_trace_tgl  <= 1'b0;
        end else if (trace_pos(rx_cur)) begin
            if (rx_in.data != rx_trace_cand) begin
                rx_trace_cand <= rx_in.data;
                rx_trace_cnt  <= 2'd1;
            end else if (rx_trace_cnt != 2'(TRACE_PERSIST)) begin
                rx_trace_cnt <= 2'(rx_trace_cnt + 2'd1);
                if (rx_trace_cnt == 2'(TRACE_PERSIST - 1) && rx_trace_cand != rx_trace_acc) begin
                    rx_trace_acc <= rx_trace_cand;
                    rx_trace_tgl <= ~rx_trace_tgl;
                end
            end
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            ais_link_sync    <= 2'b00;
            tsf_link_sync    <= 2'b00;
            rx_payload       <= '0;
            rx_payload_valid <= 1'b0;
            ms_server_fail   <= 1'b0;
        end else begin
            ais_link_sync    <= {ais_link_sync[0], all_ones_insert_action};
            tsf_link_sync    <= {tsf_link_sync[0], trail_fail_action};
            rx_payload.fs    <= rx_in.fs;
            // Refreshed after the descrambler, which would corrupt upstream all ones
            rx_payload.data  <= ais_link_sync[1] ? ONES_BYTE : rx_descr;
            rx_payload_valid <= !in_rsoh(rx_cur);
            ms_server_fail   <= tsf_link_sync[1];
        end
    end

    // ****************************************************************
    // Management side: defects and consequent actions
    // ****************************************************************
    logic [1:0] ssf_sync;
    logic [2:0] err_sync;
    logic [2:0] trace_sync;
    logic       defect;

    always_ff @(posedge mclk or negedge mrst_n) begin
        if (!mrst_n) begin
            ssf_sync               <= 2'b00;
            err_sync               <= 3'b000;
            trace_sync             <= 3'b000;
            accepted_trace_id      <= TRACE_RST;
            block_error_indication <= 1'b0;
        end else begin
            ssf_sync   <= {ssf_sync[0], server_fail_in};
            err_sync   <= {err_sync[1:0], rx_err_tgl};
            trace_sync <= {trace_sync[1:0], rx_trace_tgl};
            block_error_indication <= err_sync[2] ^ err_sync[1];
            // Accepted word is stable for a frame after its toggle
            if (trace_sync[2] ^ trace_sync[1]) begin
                accepted_trace_id <= rx_trace_acc;
            end
        end
    end

    assign defect = !mismatch_detect_disable && (accepted_trace_id != expected_trace_id);

    always_ff @(posedge mclk or negedge mrst_n) begin
        if (!mrst_n) begin
            trace_mismatch_defect  <= 1'b0;
            trace_mismatch_report  <= 1'b0;
            all_ones_insert_action <= 1'b0;
            trail_fail_action      <= 1'b0;
        end else begin
            trace_mismatch_defect  <= defect;
            trace_mismatch_report  <= monitoring_enabled && trace_mismatch_defect;
            all_ones_insert_action <= ssf_sync[1] || trace_mismatch_defect;
            trail_fail_action      <= ssf_sync[1] || trace_mismatch_defect;
        end
    end

endmodule

`default_nettype wire

// [verification/rs16_termination_assertions.sv]
/* Port-level checks for the regenerator-section termination block.
   Assumes both clocks are ports of the block and it is bound below. */
`timescale 1ns/10ps
`default_nettype none
module rs16_termination_assertions
    import rs16_pkg::*;
(
    input wire logic          mclk,                    // Management clock
    input wire logic          arst_n,                  // Reset, active low
    input wire logic          link_clk,                // Line clock
    input wire line_byte_type src_in,                  // Source bytes
    input wire line_byte_type tx_out,                  // Line bytes out
    input wire line_byte_type rx_in,                   // Line bytes in
    input wire logic          server_fail_in,          // Line fail
    input wire line_byte_type rx_payload,              // Sink bytes
    input wire logic          rx_payload_valid,        // Payload flag
    input wire logic          ms_server_fail,          // Fail to mux side
    input wire logic          mismatch_detect_disable, // Defect off
    input wire logic [7:0]    expected_trace_id,       // Expected trace
    input wire logic [7:0]    accepted_trace_id,       // Accepted trace
    input wire logic          trace_mismatch_defect,   // Defect
    input wire logic          monitoring_enabled,      // Report gate
    input wire logic          trace_mismatch_report,   // Report
    input wire logic          all_ones_insert_action,  // Sink all ones
    input wire logic          trail_fail_action        // Trail fail
);
    // ************************
    // Properties
    // ************************
    chk_ais_same: assert property (@(posedge mclk) disable iff (!arst_n)
        all_ones_insert_action == trail_fail_action) else $error("ais and trail fail differ");
    chk_ais_onset: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(server_fail_in) |-> ##[2:6] all_ones_insert_action) else $error("ais late");
    chk_defect_set: assert property (@(posedge mclk) disable iff (!arst_n)
        (!mismatch_detect_disable && accepted_trace_id != expected_trace_id)[*4]
        |-> trace_mismatch_defect) else $error("defect missing");
    chk_defect_off: assert property (@(posedge mclk) disable iff (!arst_n)
        $past(mismatch_detect_disable) |-> !trace_mismatch_defect) else $error("defect while off");
    chk_report_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        trace_mismatch_report == ($past(monitoring_enabled) && $past(trace_mismatch_defect)))
        else $error("report wrong");
    chk_align_first: assert property (@(posedge link_clk) disable iff (!arst_n)
        tx_out.fs |-> tx_out.data == A1_BYTE && $past(src_in.fs)) else $error("frame start bad");
    chk_overhead_flag: assert property (@(posedge link_clk) disable iff (!arst_n)
        rx_in.fs |=> !rx_payload_valid) else $error("overhead marked payload");
    chk_sink_ones: assert property (@(posedge link_clk) disable iff (!arst_n)
        all_ones_insert_action[*4] |-> rx_payload.data == ONES_BYTE) else $error("no all ones");
    chk_fail_copy: assert property (@(posedge link_clk) disable iff (!arst_n)
        trail_fail_action[*5] |-> ms_server_fail) else $error("fail not copied");
endmodule
bind stm16_regen_section_termination rs16_termination_assertions u_chk (.mclk, .arst_n,
    .link_clk, .src_in, .tx_out, .rx_in, .server_fail_in, .rx_payload, .rx_payload_valid,
    .ms_server_fail, .mismatch_detect_disable, .expected_trace_id, .accepted_trace_id,
    .trace_mismatch_defect, .monitoring_enabled, .trace_mismatch_report,
    .all_ones_insert_action, .trail_fail_action);
`default_nettype wire

// [verification/rs16_line_partner.sv]
/* Far-side model: feeds framed payload and loops the line back.
   Assumes the bench reset and the block's link clock. */
`timescale 1ns/10ps
`default_nettype none
module rs16_line_partner
    import rs16_pkg::*;
(
    input  wire logic          link_clk, // Line clock
    input  wire logic          rst_n,    // Reset, active low
    input  wire line_byte_type tx_out,   // Line bytes from block
    input  wire logic          corrupt,  // Flip one bit per frame
    output line_byte_type      src_in,   // Payload stream
    output line_byte_type      rx_in     // Looped line stream
);
    logic [15:0] pos;
    logic [2:0]  hold;
    always @(negedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 16'h0000;
            hold <= 3'h0;
            src_in <= '0;
            rx_in <= '0;
        end else if (hold != 3'h7) begin
            hold <= hold + 3'h1;
        end else begin
            pos <= (pos == 16'(FRAME_ROWS * FRAME_COLS - 1)) ? 16'h0000 : pos + 16'h0001;
            src_in.fs <= (pos == 16'h0000);
            // Pattern changes every byte, so no long equal-bit runs
            src_in.data <= pos[7:0] ^ 8'h5c;
            rx_in <= tx_out ^ {8'h00, corrupt && pos == 16'h2328};
        end
    end
endmodule
`default_nettype wire

// [verification/tb_stm16_regen_section_termination.sv]
/* Self-checking bench for the termination block with a looped line.
   Assumes the partner model and the bound checker are compiled too. */
`timescale 1ns/10ps
`default_nettype none
module tb_stm16_regen_section_termination import rs16_pkg::*;;
    logic          mclk, arst_n, link_clk, src_server_fail, server_fail_in, corrupt;
    logic          mismatch_detect_disable, monitoring_enabled, rx_payload_valid;
    logic          ms_server_fail, trace_mismatch_defect, trace_mismatch_report;
    logic          all_ones_insert_action, trail_fail_action, block_error_indication;
    logic [7:0]    transmit_trace_id, expected_trace_id, accepted_trace_id;
    line_byte_type src_in, tx_out, rx_in, rx_payload, tx_alt;
    int            bad_count, samples_checked;
    stm16_regen_section_termination DUT (.mclk, .arst_n, .link_clk, .src_in, .src_server_fail,
        .tx_out, .rx_in, .server_fail_in, .rx_payload, .rx_payload_valid, .ms_server_fail,
        .transmit_trace_id, .expected_trace_id, .mismatch_detect_disable, .monitoring_enabled,
        .accepted_trace_id, .trace_mismatch_defect, .trace_mismatch_report,
        .all_ones_insert_action, .trail_fail_action, .block_error_indication);
    rs16_line_partner far_end (.link_clk, .rst_n(arst_n), .tx_out, .corrupt, .src_in, .rx_in);
    // Same block with its payload fail input treated as unwired
    stm16_regen_section_termination #(.SRC_FAIL_CONNECTED(1'b0)) unwired_dut (.mclk, .arst_n,
        .link_clk, .src_in, .src_server_fail, .tx_out(tx_alt), .rx_in, .server_fail_in,
        .rx_payload(), .rx_payload_valid(), .ms_server_fail(), .transmit_trace_id,
        .expected_trace_id, .mismatch_detect_disable, .monitoring_enabled,
        .accepted_trace_id(), .trace_mismatch_defect(), .trace_mismatch_report(),
        .all_ones_insert_action(), .trail_fail_action(), .block_error_indication());
    // ************************
    // Helpers
    // ************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic give_up();
        check("wait done", 8'h00, 8'h01);
        wrap_up();
    endtask
    task automatic wait_ais(input logic want);
        int n;
        n = 0;
        while (all_ones_insert_action !== want) begin
            @(negedge mclk);
            if (++n > AIS_MAX_CYCLES) give_up();
        end
        check("ais", 8'(trail_fail_action), 8'(want));
    endtask
    // ************************
    // Scenarios
    // ************************
    task automatic t_frame();
        logic [6:0] st;
        logic [7:0] key, cur, exp;
        int n;
        n = 0;
        cur = 8'h00;
        while (tx_out.fs !== 1'b1) begin
            @(negedge link_clk);
            if (++n > 40000) give_up();
        end
        st = SCR_SEED;
        for (int c = 1; c <= 152; c++) begin
            key = 8'h00;
            if (c >= SCR_RESET_COL) for (int b = 7; b >= 0; b--) begin
                key[b] = st[6];
                st = {st[5:0], st[6] ^ st[5]};
            end
            exp = c <= A1_LAST_COL ? A1_BYTE : c <= A2_LAST_COL ? A2_BYTE :
                  c == TRACE_COL ? transmit_trace_id : c < SCR_RESET_COL ? FILL_BYTE : cur ^ key;
            check("line byte", tx_out.data, exp);
            @(posedge link_clk);
            cur = src_in.data;
            @(negedge link_clk);
        end
    endtask
    task automatic t_payload(input logic fail);
        logic [15:0] hist;
        @(negedge link_clk);
        src_server_fail = fail;
        hist = 16'h0000;
        for (int i = 0; i < 24; i++) begin
            @(posedge link_clk);
            hist = {hist[7:0], src_in.data};
            @(negedge link_clk);
            if (i > 4 && rx_payload_valid === 1'b1) begin
                check("payload", rx_payload.data, fail ? ONES_BYTE : hist[15:8]);
                // Keystreams cancel, leaving only the forced ones against the payload
                check("unwired", tx_out.data ^ tx_alt.data, fail ? ~hist[7:0] : 8'h00);
            end
        end
    endtask
    task automatic t_trace();
        @(negedge mclk);
        expected_trace_id = 8'h3c;
        repeat (4) @(negedge mclk);
        check("defect", 8'(trace_mismatch_defect), 8'h01);
        check("trail fail", 8'(trail_fail_action), 8'h01);
        check("report off", 8'(trace_mismatch_report), 8'h00);
        // Three equal frames are needed, so nothing is accepted yet
        check("accepted", accepted_trace_id, TRACE_RST);
        monitoring_enabled = 1'b1;
        repeat (2) @(negedge mclk);
        check("report on", 8'(trace_mismatch_report), 8'h01);
        mismatch_detect_disable = 1'b1;
        repeat (4) @(negedge mclk);
        check("disabled", 8'(all_ones_insert_action), 8'h00);
        mismatch_detect_disable = 1'b0;
        expected_trace_id = 8'h00;
    endtask
    task automatic t_server_fail();
        @(negedge link_clk);
        server_fail_in = 1'b1;
        wait_ais(1'b1);
        repeat (8) @(negedge link_clk);
        check("sink ones", rx_payload.data, ONES_BYTE);
        check("mux fail", 8'(ms_server_fail), 8'h01);
        server_fail_in = 1'b0;
        wait_ais(1'b0);
    endtask
    task automatic t_parity();
        int n;
        n = 0;
        while (block_error_indication !== 1'b1) begin
            @(negedge mclk);
            if (++n > 60000) give_up();
        end
        @(negedge mclk);
        check("error pulse", 8'(block_error_indication), 8'h00);
    endtask
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #17;
        forever #62.5 link_clk = ~link_clk;
    end
    initial begin
        {arst_n, src_server_fail, server_fail_in, mismatch_detect_disable} = 4'h0;
        monitoring_enabled = 1'b0;
        corrupt = 1'b1;
        transmit_trace_id = 8'h3c;
        expected_trace_id = 8'h00;
        bad_count = 0;
        samples_checked = 0;
        repeat (10) @(negedge mclk);
        arst_n = 1'b1;
        t_frame();
        t_payload(1'b1);
        t_payload(1'b0);
        t_trace();
        t_server_fail();
        t_parity();
        wrap_up();
    end
endmodule
`default_nettype wire
